// ===== psds_deadband.sv
`timescale 1ns/1ps
module psds_deadband #(
    parameter int CW = 7
) (
    // Clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          ce_in,
    // Waveform
    input  wire logic          active_in,
    input  wire logic [CW-1:0] count_in,
    output logic               active_out
);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          done;
    logic          out_d;

    // Counts cycles of input activity, saturating at the programmed delay
    assign done  = (cnt_q >= count_in);
    assign cnt_d = !active_in ? '0 : (done ? cnt_q : cnt_q + 1'b1);
    // A pulse shorter than the delay never shows at all
    assign out_d = active_in && done;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q      <= '0;
            active_out <= 1'b0;
        end else if (ce_in) begin
            cnt_q      <= cnt_d;
            active_out <= out_d;
        end
    end

    default clocking db_cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_db_fall_now: assert property (ce_in && !active_in |=> !active_out)
        else $error("Dead band delayed a falling edge");
    a_db_rise_late: assert property ($rose(active_out) |-> $past(cnt_q) >= $past(count_in))
        else $error("Output went active before the dead band elapsed");
    a_db_hold_off: assert property (ce_in && active_in && cnt_q < count_in |=> !active_out)
        else $error("Output active while dead band still counting");

endmodule

// ===== psds_far_model.sv
`timescale 1ns/1ps
module psds_far_model #(
    parameter int PER  = 16,
    parameter int DUTY = 8
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Pin side
    input  wire logic [3:0] pin_in,
    input  wire logic [3:0] oe_in,
    output logic      [3:0] pin_level_out,
    // Timebase
    output logic            pwm_raw_out,
    output logic            period_start_out
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    assign cnt_d = (cnt_q == 8'(PER - 1)) ? 8'h00 : cnt_q + 8'h01;
    // Released pins fall to the gate-driver pull-downs
    assign pin_level_out = pin_in & oe_in;

    // Registered like a real timer, so edges land just after the clock
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q            <= 8'h00;
            pwm_raw_out      <= 1'b0;
            period_start_out <= 1'b0;
        end else begin
            cnt_q            <= cnt_d;
            pwm_raw_out      <= (cnt_q < 8'(DUTY));
            period_start_out <= (cnt_q == 8'h00);
        end
    end
endmodule

// ===== psds_pkg.sv
package psds_pkg;

    // Register map, byte addresses on the APB word grid
    localparam logic [11:0] OFS_SHUTDOWN = 12'h000;
    localparam logic [11:0] OFS_RESTART  = 12'h004;
    localparam logic [11:0] OFS_STEERING = 12'h008;
    localparam logic [11:0] OFS_MODE     = 12'h00c;

    // Field positions
    localparam int FLAG_BIT  = 7;
    localparam int SRC_LSB   = 4;
    localparam int PAC_LSB   = 2;
    localparam int PBD_LSB   = 0;
    localparam int AUTO_BIT  = 7;
    localparam int SYNC_BIT  = 4;
    localparam int BRIDGE_LSB = 6;

    // Values after reset
    localparam logic [7:0] RST_SHUTDOWN = 8'h00;
    localparam logic [7:0] RST_RESTART  = 8'h00;
    localparam logic [7:0] RST_STEERING = 8'h01;
    localparam logic [7:0] RST_MODE     = 8'h00;

    // Upper mode bits that select PWM operation
    localparam logic [1:0] MODE_PWM = 2'h3;

    typedef enum logic [1:0] {
        BR_SINGLE   = 2'h0,
        BR_FULL_FWD = 2'h1,
        BR_HALF     = 2'h2,
        BR_FULL_REV = 2'h3
    } psds_bridge_t;

    // Gray along idle -> arm -> run -> shut; shut -> arm flips both bits
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ARM  = 2'h1,
        ST_RUN  = 2'h3,
        ST_SHUT = 2'h2
    } psds_state_t;

endpackage

// ===== psds_top.sv
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module psds_top #(
    parameter int DB_W = 7
) (
    // Clock, reset, enable
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        CLK_EN_IN,
    // APB slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // Timebase
    input  wire logic        PWM_RAW_IN,
    input  wire logic        PERIOD_START_IN,
    // Shutdown sources
    input  wire logic        FAULT_PIN_N_IN,
    input  wire logic        CMP_ONE_IN,
    input  wire logic        CMP_TWO_IN,
    // Output pins, bit 0 is A through bit 3 is D
    output logic      [3:0]  PWM_PIN_OUT,
    output logic      [3:0]  PWM_OE_OUT
);

    function automatic logic src_trig(input logic [2:0] sel, input logic flt_n,
                                      input logic c1, input logic c2);
        logic cmp;
        cmp = 1'b0;
        unique case (sel[1:0])
            2'h0: cmp = 1'b0;
            2'h1: cmp = c1;
            2'h2: cmp = c2;
            2'h3: cmp = c1 | c2;
        endcase
        return (sel[2] & ~flt_n) | cmp;
    endfunction

    // Registers
    logic                      flag_q;
    logic                      flag_d;
    logic [2:0]                src_q;
    logic [1:0]                pac_q;
    logic [1:0]                pbd_q;
    logic                      auto_q;
    logic [DB_W-1:0]           db_q;
    logic                      sync_q;
    logic [3:0]                steer_sh_q;
    logic [3:0]                steer_eff_q;
    logic [3:0]                steer_eff_d;
    logic [3:0]                modepol_q;
    psds_pkg::psds_bridge_t    bridge_q;
    psds_pkg::psds_state_t     st_q;
    psds_pkg::psds_state_t     st_d;
    logic [3:0]                norm_pin_q;
    logic [3:0]                norm_oe_q;
    logic                      pready_q;
    logic                      pslverr_q;
    logic [31:0]               prdata_q;

    // Bus decode
    logic                      setup;
    logic                      wr_en;
    logic                      hit_sd;
    logic                      hit_rs;
    logic                      hit_st;
    logic                      hit_md;
    logic                      mapped;
    logic                      wr_sd;
    logic                      wr_rs;
    logic                      wr_st;
    logic                      wr_md;
    logic [7:0]                rd_byte;
    logic [7:0]                wb;

    assign setup  = PSEL_IN && !PENABLE_IN;
    assign wr_en  = PSEL_IN && PENABLE_IN && PWRITE_IN && pready_q;
    assign hit_sd = (PADDR_IN == psds_pkg::OFS_SHUTDOWN);
    assign hit_rs = (PADDR_IN == psds_pkg::OFS_RESTART);
    assign hit_st = (PADDR_IN == psds_pkg::OFS_STEERING);
    assign hit_md = (PADDR_IN == psds_pkg::OFS_MODE);
    assign mapped = hit_sd | hit_rs | hit_st | hit_md;
    assign wr_sd  = wr_en && hit_sd;
    assign wr_rs  = wr_en && hit_rs;
    assign wr_st  = wr_en && hit_st;
    assign wr_md  = wr_en && hit_md;
    assign wb     = PWDATA_IN[7:0];

    assign rd_byte = hit_sd ? {flag_q, src_q, pac_q, pbd_q} :
                     hit_rs ? {auto_q, db_q} :
                     hit_st ? {3'h0, sync_q, steer_sh_q} :
                     hit_md ? {bridge_q, 2'h0, modepol_q} : 8'h00;

    // Shutdown trigger and event flag
    logic trig;
    logic fw_set;
    logic fw_clr;
    logic auto_clr;
    logic shut_any;

    assign trig     = src_trig(src_q, FAULT_PIN_N_IN, CMP_ONE_IN, CMP_TWO_IN);
    assign fw_set   = wr_sd && wb[psds_pkg::FLAG_BIT];
    // Flag clear writes are ignored while the trigger level is present
    assign fw_clr   = wr_sd && !wb[psds_pkg::FLAG_BIT] && !trig;
    assign auto_clr = auto_q && !trig;
    // Setting beats clearing so an event in the clear cycle is kept
    assign flag_d   = trig || fw_set || (flag_q && !fw_clr && !auto_clr);
    // Trigger is combinational so pins react before the next edge
    assign shut_any = trig || flag_q || (st_q == psds_pkg::ST_SHUT);

    // Mode and steering
    logic       pwm_en;
    logic       steer_mode;
    logic [1:0] db_out;
    logic [3:0] mode_en;
    logic [3:0] mode_val;
    logic [3:0] pol;
    logic [3:0] norm_pin_d;
    logic [3:0] norm_oe_d;

    assign pwm_en     = (modepol_q[3:2] == psds_pkg::MODE_PWM);
    assign steer_mode = pwm_en && (bridge_q == psds_pkg::BR_SINGLE);
    // Synchronised updates wait for the period edge to avoid runt pulses
    assign steer_eff_d = (wr_st && !wb[psds_pkg::SYNC_BIT]) ? wb[3:0] :
                         (PERIOD_START_IN && sync_q) ? steer_sh_q : steer_eff_q;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_db
            psds_deadband #(.CW(DB_W)) u_db (
                .clk_in     (CORE_CLK_IN),
                .rst_n_in   (RST_N_IN),
                .ce_in      (CLK_EN_IN),
                .active_in  ((g == 0) ? PWM_RAW_IN : !PWM_RAW_IN),
                .count_in   (db_q),
                .active_out (db_out[g])
            );
        end
    endgenerate

    assign mode_en  = !pwm_en ? 4'h0 :
                      steer_mode ? steer_eff_q :
                      (bridge_q == psds_pkg::BR_HALF) ? 4'h3 : 4'hf;
    assign mode_val = steer_mode ? {4{PWM_RAW_IN}} :
                      (bridge_q == psds_pkg::BR_HALF) ? {2'h0, db_out} :
                      (bridge_q == psds_pkg::BR_FULL_FWD) ? {PWM_RAW_IN, 3'h1} :
                      {2'h1, PWM_RAW_IN, 1'b0};
    // Bit 1 sets A/C active low, bit 0 sets B/D active low
    assign pol        = {modepol_q[0], modepol_q[1], modepol_q[0], modepol_q[1]};
    assign norm_pin_d = ((st_q == psds_pkg::ST_RUN) ? mode_val : 4'h0) ^ pol;
    assign norm_oe_d  = (st_q == psds_pkg::ST_IDLE) ? 4'h0 : mode_en;

    // Output sequencing
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            psds_pkg::ST_IDLE: if (pwm_en) st_d = psds_pkg::ST_ARM;
            psds_pkg::ST_ARM:  if (shut_any) st_d = psds_pkg::ST_SHUT;
                               else if (PERIOD_START_IN) st_d = psds_pkg::ST_RUN;
            psds_pkg::ST_RUN:  if (shut_any) st_d = psds_pkg::ST_SHUT;
            psds_pkg::ST_SHUT: if (!trig && !flag_q) st_d = psds_pkg::ST_ARM;
        endcase
        if (!pwm_en) st_d = psds_pkg::ST_IDLE;
    end

    // Pin stage, pairs A/C and B/D share a shutdown state
    generate
        for (g = 0; g < 4; g++) begin : g_pin
            logic [1:0] pss;
            logic       force_pin;
            assign pss       = (g % 2 == 0) ? pac_q : pbd_q;
            // Only pins the block already owns are taken over
            assign force_pin = shut_any && norm_oe_q[g];
            assign PWM_PIN_OUT[g] = force_pin ? (!pss[1] && pss[0]) : norm_pin_q[g];
            assign PWM_OE_OUT[g]  = force_pin ? !pss[1] : norm_oe_q[g];
        end
    endgenerate

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            {flag_q, src_q, pac_q, pbd_q} <= psds_pkg::RST_SHUTDOWN;
            {auto_q, db_q}                <= psds_pkg::RST_RESTART;
            sync_q                        <= psds_pkg::RST_STEERING[psds_pkg::SYNC_BIT];
            steer_sh_q                    <= psds_pkg::RST_STEERING[3:0];
            steer_eff_q                   <= psds_pkg::RST_STEERING[3:0];
            modepol_q                     <= psds_pkg::RST_MODE[3:0];
            bridge_q                      <= psds_pkg::BR_SINGLE;
        end else if (CLK_EN_IN) begin
            flag_q      <= flag_d;
            steer_eff_q <= steer_eff_d;
            if (wr_sd) begin
                src_q <= wb[psds_pkg::SRC_LSB +: 3];
                pac_q <= wb[psds_pkg::PAC_LSB +: 2];
                pbd_q <= wb[psds_pkg::PBD_LSB +: 2];
            end
            if (wr_rs) begin
                auto_q <= wb[psds_pkg::AUTO_BIT];
                db_q   <= wb[DB_W-1:0];
            end
            if (wr_st) begin
                sync_q     <= wb[psds_pkg::SYNC_BIT];
                steer_sh_q <= wb[3:0];
            end
            if (wr_md) begin
                modepol_q <= wb[3:0];
                bridge_q  <= psds_pkg::psds_bridge_t'(wb[psds_pkg::BRIDGE_LSB +: 2]);
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_q       <= psds_pkg::ST_IDLE;
            norm_pin_q <= 4'h0;
            norm_oe_q  <= 4'h0;
        end else if (CLK_EN_IN) begin
            st_q       <= st_d;
            norm_pin_q <= norm_pin_d;
            norm_oe_q  <= norm_oe_d;
        end
    end

    // Answer is prepared in the setup cycle so the access needs no wait
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (CLK_EN_IN) begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            prdata_q  <= setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    assign PREADY_OUT  = pready_q;
    assign PSLVERR_OUT = pslverr_q;
    assign PRDATA_OUT  = prdata_q;

    default clocking top_cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_src_comp_one: assert property (src_q == 3'h1 && CMP_ONE_IN |-> trig)
        else $error("Comparator one did not trigger shutdown");
    a_src_off: assert property (src_q == 3'h0 |-> !trig)
        else $error("Shutdown triggered with source disabled");
    a_trig_sets_flag: assert property (CLK_EN_IN && trig |=> flag_q)
        else $error("Trigger level did not hold the event flag");
    a_fw_set_event: assert property (CLK_EN_IN && fw_set |=> flag_q ##0 shut_any)
        else $error("Firmware set did not shut down");
    a_ac_low_state: assert property (trig && norm_oe_q[0] && pac_q == 2'h0
                                     |-> !PWM_PIN_OUT[0] && PWM_OE_OUT[0])
        else $error("Pin A not driven low at once on shutdown");
    a_bd_high_state: assert property (flag_q && norm_oe_q[1] && pbd_q == 2'h1
                                      |-> PWM_PIN_OUT[1] && PWM_OE_OUT[1])
        else $error("Pin B not driven high in shutdown");
    a_no_clear_held: assert property (CLK_EN_IN && trig && wr_sd && !wb[7] |=> flag_q)
        else $error("Flag cleared while condition present");
    a_wait_period: assert property (CLK_EN_IN && st_q == psds_pkg::ST_ARM && !PERIOD_START_IN
                                    && pwm_en |=> st_q != psds_pkg::ST_RUN)
        else $error("Waveform resumed before period start");
    a_auto_clear: assert property (CLK_EN_IN && auto_q && flag_q && !trig && !fw_set
                                   |=> !flag_q)
        else $error("Auto restart did not clear the flag");
    a_steer_only: assert property (CLK_EN_IN && pwm_en && st_q != psds_pkg::ST_IDLE
                                   && bridge_q != psds_pkg::BR_SINGLE
                                   && bridge_q != psds_pkg::BR_HALF |=> norm_oe_q == 4'hf)
        else $error("Steering applied outside single mode");
    a_steer_free: assert property (CLK_EN_IN && steer_mode && !steer_eff_q[2]
                                   |=> !PWM_OE_OUT[2])
        else $error("Unsteered pin still driven");
    a_sync_hold: assert property (CLK_EN_IN && wr_st && wb[4] && !PERIOD_START_IN && !sync_q
                                  |=> steer_eff_q == $past(steer_eff_q))
        else $error("Synchronised steering applied early");
    a_hiz_pair: assert property (shut_any && norm_oe_q[0] && norm_oe_q[2] && pac_q[1]
                                 |-> !PWM_OE_OUT[0] && !PWM_OE_OUT[2])
        else $error("High impedance pair still enabled");

    c_fault_shut: cover property (src_q[2] && !FAULT_PIN_N_IN && PWM_OE_OUT[0]);
    c_auto_restart: cover property (auto_q && flag_q ##1 !flag_q ##[1:50] st_q == psds_pkg::ST_RUN);
    c_sync_steer: cover property (sync_q && PERIOD_START_IN && steer_sh_q != steer_eff_q);
    c_half_delay: cover property (bridge_q == psds_pkg::BR_HALF && db_q > 7'h2 && $rose(db_out[0]));

endmodule

// ===== pwm_shutdown_deadband_steering_tb_top.sv
`timescale 1ns/1ps
module pwm_shutdown_deadband_steering_tb_top;
    logic        clk = 1'b0;
    logic        rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        pwm_raw, per_start, fault_n, cmp_one, cmp_two, raw_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pins, oe, level;
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    psds_top u_dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(1'b1),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .PWM_RAW_IN(pwm_raw), .PERIOD_START_IN(per_start),
        .FAULT_PIN_N_IN(fault_n), .CMP_ONE_IN(cmp_one), .CMP_TWO_IN(cmp_two),
        .PWM_PIN_OUT(pins), .PWM_OE_OUT(oe));
    psds_far_model u_far (.clk_in(clk), .rst_n_in(rst_n), .pin_in(pins), .oe_in(oe),
        .pin_level_out(level), .pwm_raw_out(pwm_raw), .period_start_out(per_start));

    always #20 clk = ~clk;
    always @(posedge clk) raw_q <= pwm_raw;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) failures++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(exp, rd);
    endtask

    task automatic wait_period();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (per_start !== 1'b1 && n < 40);
    endtask

    // Pin A must track the timebase one cycle late
    task automatic follow(input int n, input logic inv, input logic [3:0] exp_oe);
        repeat (2) @(posedge clk);
        repeat (n) begin
            @(negedge clk);
            chk(32'(raw_q ^ inv), 32'(pins[0]));
            chk(32'(exp_oe), 32'(oe));
        end
    endtask

    task automatic restart_chk();
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        do begin
            @(negedge clk);
            chk(32'h0, 32'(pins[0]));
            n++;
        end while (per_start !== 1'b1 && n < 40);
        follow(16, 1'b0, 4'h1);
    endtask

    task automatic results();
        $display("Counts: failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        int ca;
        int cb;
        int ov;
        int ex;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fault_n = 1'b1;
        cmp_one = 1'b0;
        cmp_two = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(psds_pkg::OFS_SHUTDOWN, 32'h00);
        rdchk(psds_pkg::OFS_RESTART, 32'h00);
        rdchk(psds_pkg::OFS_STEERING, 32'h01);
        rdchk(psds_pkg::OFS_MODE, 32'h00);
        apb(1'b0, 12'h010, 32'h0);
        chk(32'h1, 32'(err));
        chk(32'h0, rd);
        apb(1'b1, psds_pkg::OFS_STEERING, 32'hff);
        rdchk(psds_pkg::OFS_STEERING, 32'h1f);
        apb(1'b1, psds_pkg::OFS_STEERING, 32'h01);
        apb(1'b1, psds_pkg::OFS_MODE, 32'h0c);
        wait_period();
        follow(20, 1'b0, 4'h1);
        apb(1'b1, psds_pkg::OFS_MODE, 32'h0e);
        follow(20, 1'b1, 4'h1);
        apb(1'b1, psds_pkg::OFS_MODE, 32'h0c);
        for (int s = 1; s < 8; s++) begin
            ex = (s << 4) | ((s & 1) << 2);
            apb(1'b1, psds_pkg::OFS_SHUTDOWN, 32'(ex));
            @(posedge clk);
            if (s[2]) fault_n <= 1'b0;
            else if (s[0]) cmp_one <= 1'b1;
            else cmp_two <= 1'b1;
            @(negedge clk);
            chk(32'(s & 1), 32'(pins[0]));
            apb(1'b1, psds_pkg::OFS_SHUTDOWN, 32'(ex));
            rdchk(psds_pkg::OFS_SHUTDOWN, 32'(ex | 32'h80));
            @(negedge clk);
            chk(32'(s & 1), 32'(pins[0]));
            @(posedge clk);
            fault_n <= 1'b1;
            cmp_one <= 1'b0;
            cmp_two <= 1'b0;
            wait_period();
            apb(1'b1, psds_pkg::OFS_SHUTDOWN, 32'(ex));
            restart_chk();
        end
        apb(1'b1, psds_pkg::OFS_RESTART, 32'h80);
        apb(1'b1, psds_pkg::OFS_SHUTDOWN, 32'h40);
        @(posedge clk);
        fault_n <= 1'b0;
        rdchk(psds_pkg::OFS_SHUTDOWN, 32'hc0);
        @(posedge clk);
        fault_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(psds_pkg::OFS_SHUTDOWN, 32'h40);
        apb(1'b1, psds_pkg::OFS_RESTART, 32'h00);
        apb(1'b1, psds_pkg::OFS_STEERING, 32'h03);
        apb(1'b1, psds_pkg::OFS_SHUTDOWN, 32'h89);
        @(negedge clk);
        chk(32'h2, 32'(oe));
        chk(32'h2, 32'(level));
        apb(1'b1, psds_pkg::OFS_SHUTDOWN, 32'h09);
        rdchk(psds_pkg::OFS_SHUTDOWN, 32'h09);
        apb(1'b1, psds_pkg::OFS_STEERING, 32'h04);
        @(posedge clk);
        @(negedge clk);
        chk(32'h4, 32'(oe));
        wait_period();
        apb(1'b1, psds_pkg::OFS_STEERING, 32'h18);
        @(negedge clk);
        chk(32'h4, 32'(oe));
        wait_period();
        @(posedge clk);
        @(negedge clk);
        chk(32'h8, 32'(oe));
        apb(1'b1, psds_pkg::OFS_STEERING, 32'h01);
        apb(1'b1, psds_pkg::OFS_MODE, 32'h00);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(32'h0, 32'(oe));
        apb(1'b1, psds_pkg::OFS_MODE, 32'h8c);
        for (int i = 0; i < 3; i++) begin
            ex = (i == 0) ? 0 : (i == 1) ? 5 : 127;
            apb(1'b1, psds_pkg::OFS_RESTART, 32'(ex));
            wait_period();
            repeat (2) @(posedge clk);
            ca = 0;
            cb = 0;
            ov = 0;
            repeat (16) begin
                @(negedge clk);
                ca += int'(pins[0] === 1'b1);
                cb += int'(pins[1] === 1'b1);
                ov += int'(pins[0] === 1'b1 && pins[1] === 1'b1);
            end
            ex = (ex < 8) ? 8 - ex : 0;
            chk(32'(ex), 32'(ca));
            chk(32'(ex), 32'(cb));
            chk(32'h0, 32'(ov));
            chk(32'h3, 32'(oe));
        end
        // Full bridge forward owns all four pins, so steering enables must not apply
        apb(1'b1, psds_pkg::OFS_MODE, 32'h4c);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(32'hf, 32'(oe));
        chk(32'h1, 32'(pins[0]));
        results();
    end
endmodule
